// file: common/atlt_pkg.sv
// constants, types and helpers shared by the link tuning register bank
package atlt_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned LVL_W = 12;
    localparam int unsigned FMT_W = 6;

    localparam logic [7:0] LINK_TUNING_CTRL_OFS = 8'hF4;
    localparam logic [31:0] LINK_TUNING_CTRL_RST = 32'h0000_1000;
    localparam logic [15:0] LINK_TUNING_CTRL_WMASK = 16'hB582;

    localparam int unsigned HC_GATE_BIT = 22;
    localparam int unsigned TX_REORDER_OFF_BIT = 15;
    localparam int unsigned THRESH_LSB = 12;
    localparam int unsigned MPEG_STAMP_BIT = 10;
    localparam int unsigned DV_STAMP_BIT = 8;
    localparam int unsigned PRIO_ARB_BIT = 7;
    localparam int unsigned ACCEL_BIT = 1;

    localparam logic [1:0] THR_SEL_2K = 2'h0;
    localparam logic [1:0] THR_SEL_1K7 = 2'h1;
    localparam logic [1:0] THR_SEL_1K = 2'h2;
    localparam logic [1:0] THR_SEL_512 = 2'h3;
    localparam logic [LVL_W-1:0] THR_BYTES_2K = 12'h800;
    localparam logic [LVL_W-1:0] THR_BYTES_1K7 = 12'h6CC;
    localparam logic [LVL_W-1:0] THR_BYTES_1K = 12'h400;
    localparam logic [LVL_W-1:0] THR_BYTES_512 = 12'h200;

    localparam logic [FMT_W-1:0] FMT_MPEG = 6'h20;
    localparam logic [FMT_W-1:0] FMT_DV = 6'h00;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SEND
    } atlt_state_t;

    function automatic logic atlt_hit(input logic [ADR_W-1:0] adr);
        atlt_hit = (adr == LINK_TUNING_CTRL_OFS);
    endfunction : atlt_hit

    function automatic logic [15:0] atlt_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic [1:0] sel);
        logic [15:0] res;
        res = old_v;
        for (int i = 0; i < 2; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        atlt_merge = res & LINK_TUNING_CTRL_WMASK;
    endfunction : atlt_merge

    function automatic logic [LVL_W-1:0] atlt_thr_bytes(input logic [1:0] sel);
        case (sel)
            THR_SEL_1K7: atlt_thr_bytes = THR_BYTES_1K7;
            THR_SEL_1K: atlt_thr_bytes = THR_BYTES_1K;
            THR_SEL_512: atlt_thr_bytes = THR_BYTES_512;
            default: atlt_thr_bytes = THR_BYTES_2K;
        endcase
    endfunction : atlt_thr_bytes
endpackage : atlt_pkg

// file: common/atlt_bus_if.sv
// register access carrier between the bus port and the register bank
`timescale 1ns/1ps
`default_nettype none
interface atlt_bus_if;
    logic wr;
    logic rd;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    modport port (output wr, output rd, output adr, output sel, output wdat, input rdat);
    modport regs (input wr, input rd, input adr, input sel, input wdat, output rdat);
endinterface : atlt_bus_if
`default_nettype wire

// file: design/atlt_wb_port.sv
// classic wishbone slave handshake for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module atlt_wb_port (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    atlt_bus_if.port bus
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } atlt_wbp_t;

    atlt_wbp_t s_reg;
    atlt_wbp_t s_next;

    always_comb begin
        // reads are taken as the request arrives; a write commits only at the edge that completes it
        bus.wr = wb_cyc_i & wb_stb_i & wb_we_i & s_reg.ack;
        bus.rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_reg.ack;
        bus.adr = wb_adr_i;
        bus.sel = wb_sel_i;
        bus.wdat = wb_dat_i;
        s_next = s_reg;
        s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        s_next.dat = bus.rd ? bus.rdat : 32'h0000_0000;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
endmodule : atlt_wb_port
`default_nettype wire

// file: design/atlt_stamp.sv
// picks which transmit streams get the timestamp enhancement
`timescale 1ns/1ps
`default_nettype none
module atlt_stamp (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic mpeg_en,
    input wire logic dv_en,
    input wire logic stream_valid,
    input wire logic [5:0] stream_format_code,
    output logic mpeg_fix,
    output logic dv_fix
);
    typedef struct packed {
        logic have;
        logic [5:0] code;
        logic mpeg;
        logic dv;
    } atlt_stamp_t;

    atlt_stamp_t s_reg;
    atlt_stamp_t s_next;

    always_comb begin
        s_next = s_reg;
        if (stream_valid) begin
            s_next.have = 1'b1;
            s_next.code = stream_format_code;
        end
        s_next.mpeg = mpeg_en & s_next.have & (s_next.code == atlt_pkg::FMT_MPEG); // R11
        s_next.dv = dv_en & s_next.have & (s_next.code == atlt_pkg::FMT_DV); // R12
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign mpeg_fix = s_reg.mpeg;
    assign dv_fix = s_reg.dv;
endmodule : atlt_stamp
`default_nettype wire

// file: design/async_tx_link_tuning.sv
// link tuning register bank and asynchronous transmit start control
// Notes on behaviour
// R1 - enhancement bits act only while gate bit set
// R2 - software or eeprom load may initialise bits
// R3 - bits 31-16, 14, 11, 9 read zero
// R4 - reorder-off bit forces in-order transmit
// R5 - two-bit field picks initial start threshold
// R6 - underrun or retry falls back to 2K
// R7 - start at threshold or complete packet
// R8 - drained fifo mid-packet flags underrun, store-forward
// R9 - 2K threshold sends only complete packets
// R10 - retries register cleared forces store-and-forward
// R11 - bit 10 enables mpeg stream stamp fix
// R12 - bit 8 enables dv stream stamp fix
// R13 - bit 7 enables priority arbitration
// R14 - bit 1 tells phy acceleration is supported
// R15 - bits 5-2 and 0 read zero
// R16 - writes to fixed bits are ignored
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module async_tx_link_tuning (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ee_load_valid,
    input wire logic [15:0] ee_load_data,
    input wire logic [31:0] hc_ctrl,
    input wire logic [31:0] async_tx_retry_limits,
    input wire logic [11:0] fifo_level,
    input wire logic fifo_empty,
    input wire logic pkt_pending,
    input wire logic pkt_complete,
    input wire logic pkt_retry,
    input wire logic tx_end,
    input wire logic stream_valid,
    input wire logic [5:0] stream_format_code,
    output logic tx_go,
    output logic tx_underrun,
    output logic tx_store_fwd,
    output logic tx_reorder_off,
    output logic prio_arb_en,
    output logic phy_accel_en,
    output logic mpeg_stamp_fix_en,
    output logic dv_stamp_fix_en
);
    typedef struct packed {
        logic [15:0] ltc;
        logic sf_lat;
        atlt_pkg::atlt_state_t st;
        logic go;
        logic unr;
        logic sf;
        logic reorder;
        logic prio;
        logic accel;
    } atlt_top_t;

    atlt_top_t s_reg;
    atlt_top_t s_next;
    atlt_bus_if bus ();

    logic gate_on;
    logic [15:0] eff;
    logic sf_now;
    logic start_ok;
    logic thr_wr;

    atlt_wb_port i_atlt_wb_port (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(bus.port)
    );

    atlt_stamp i_atlt_stamp (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mpeg_en(eff[atlt_pkg::MPEG_STAMP_BIT]),
        .dv_en(eff[atlt_pkg::DV_STAMP_BIT]),
        .stream_valid(stream_valid),
        .stream_format_code(stream_format_code),
        .mpeg_fix(mpeg_stamp_fix_en),
        .dv_fix(dv_stamp_fix_en)
    );

    always_comb begin
        // reserved and fixed bits are masked out of the stored word and read back as zero
        bus.rdat = 32'h0000_0000;
        if (atlt_pkg::atlt_hit(bus.adr)) begin
            bus.rdat = {16'h0000, s_reg.ltc & atlt_pkg::LINK_TUNING_CTRL_WMASK}; // R3 R15
        end
    end

    always_comb begin
        // with the gate off every output except the read data behaves as if the reset settings were stored
        gate_on = hc_ctrl[atlt_pkg::HC_GATE_BIT];
        eff = gate_on ? s_reg.ltc : atlt_pkg::LINK_TUNING_CTRL_RST[15:0]; // R1
        // retried packets, a latched earlier underrun and zero retries all wait for the whole packet
        sf_now = (eff[atlt_pkg::THRESH_LSB +: 2] == atlt_pkg::THR_SEL_2K) // R9
               | s_reg.sf_lat // R6
               | pkt_retry // R6
               | (async_tx_retry_limits == 32'h0000_0000); // R10
        start_ok = pkt_complete
                 | (~sf_now & (fifo_level >= atlt_pkg::atlt_thr_bytes(eff[atlt_pkg::THRESH_LSB +: 2]))); // R5 R7
        thr_wr = bus.wr & atlt_pkg::atlt_hit(bus.adr) & bus.sel[1];
    end

    always_comb begin
        s_next = s_reg;
        s_next.go = 1'b0;
        s_next.unr = 1'b0;
        if (ee_load_valid) begin
            s_next.ltc = ee_load_data & atlt_pkg::LINK_TUNING_CTRL_WMASK; // R2 R16
        end
        // a bus write in the same cycle as a load lands on top of it
        if (bus.wr && atlt_pkg::atlt_hit(bus.adr)) begin
            s_next.ltc = atlt_pkg::atlt_merge(s_next.ltc, bus.wdat[15:0], bus.sel[1:0]); // R2 R16
        end
        // rewriting the threshold re-arms cut-through; an underrun in the same cycle wins
        if (thr_wr || ee_load_valid) begin
            s_next.sf_lat = 1'b0;
        end
        case (s_reg.st)
            atlt_pkg::ST_IDLE: begin
                if (pkt_pending && start_ok) begin
                    s_next.go = 1'b1;
                    s_next.st = atlt_pkg::ST_SEND;
                end
            end
            atlt_pkg::ST_SEND: begin
                if (tx_end) begin
                    s_next.st = atlt_pkg::ST_IDLE;
                end else if (fifo_empty && !pkt_complete) begin
                    s_next.unr = 1'b1; // R8
                    s_next.sf_lat = 1'b1; // R8
                    s_next.st = atlt_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next.st = atlt_pkg::ST_IDLE;
            end
        endcase
        s_next.sf = sf_now;
        s_next.reorder = eff[atlt_pkg::TX_REORDER_OFF_BIT]; // R4
        s_next.prio = eff[atlt_pkg::PRIO_ARB_BIT]; // R13
        s_next.accel = eff[atlt_pkg::ACCEL_BIT]; // R14
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.ltc <= atlt_pkg::LINK_TUNING_CTRL_RST[15:0];
            s_reg.st <= atlt_pkg::ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_go = s_reg.go;
    assign tx_underrun = s_reg.unr;
    assign tx_store_fwd = s_reg.sf;
    assign tx_reorder_off = s_reg.reorder;
    assign prio_arb_en = s_reg.prio;
    assign phy_accel_en = s_reg.accel;
endmodule : async_tx_link_tuning
`default_nettype wire

// file: tb/async_tx_link_tuning_sva.sv
// port assertions for the link tuning register bank
`timescale 1ns/1ps
`default_nettype none
module atlt_sva (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic fifo_empty,
    input wire logic pkt_pending,
    input wire logic pkt_complete,
    input wire logic pkt_retry,
    input wire logic tx_go,
    input wire logic tx_underrun,
    input wire logic tx_store_fwd,
    input wire logic tx_reorder_off,
    input wire logic prio_arb_en,
    input wire logic phy_accel_en,
    input wire logic mpeg_stamp_fix_en,
    input wire logic dv_stamp_fix_en,
    input wire logic [31:0] wb_dat_o,
    input wire logic [31:0] hc_ctrl,
    input wire logic [31:0] async_tx_retry_limits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing or too long");
    property p_rsvd;
        wb_ack_o |-> (wb_dat_o & 32'hFFFF4A7D) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("fixed bit read nonzero");
    property p_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    // every enable output must be dead one cycle after the gate drops
    property p_gate;
        !hc_ctrl[22] |=> !(tx_reorder_off || prio_arb_en || phy_accel_en || mpeg_stamp_fix_en || dv_stamp_fix_en);
    endproperty
    a_gate: assert property (p_gate) else $error("enhancement active with gate off");
    property p_go;
        tx_go |-> $past(pkt_pending) ##1 !tx_go;
    endproperty
    a_go: assert property (p_go) else $error("start pulse without packet");
    property p_sf;
        (pkt_retry || async_tx_retry_limits == 32'h0) |=> tx_store_fwd;
    endproperty
    a_sf: assert property (p_sf) else $error("store and forward not in force");
    property p_whole;
        tx_go && ($past(pkt_retry) || $past(async_tx_retry_limits) == 32'h0) |-> $past(pkt_complete);
    endproperty
    a_whole: assert property (p_whole) else $error("partial packet sent");
    property p_urun;
        tx_underrun |-> $past(fifo_empty) && !$past(pkt_complete) ##1 tx_store_fwd;
    endproperty
    a_urun: assert property (p_urun) else $error("bad underrun");
endmodule : atlt_sva
`default_nettype wire

// file: tb/async_tx_link_tuning_tb.sv
// self-checking bench for the link tuning register bank
`timescale 1ns/1ps
`default_nettype none
module async_tx_link_tuning_tb;
    logic core_clk = '0, rst_b = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, ee_load_valid = '0;
    logic fifo_empty = '0, pkt_pending = '0, pkt_complete = '0, pkt_retry = '0, tx_end = '0, stream_valid = '0;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, hc_ctrl = '0, async_tx_retry_limits = 32'h1, wb_dat_o;
    logic [15:0] ee_load_data = '0;
    logic [11:0] fifo_level = '0;
    logic [5:0] stream_format_code = '0;
    logic wb_ack_o, tx_go, tx_underrun, tx_store_fwd, tx_reorder_off, prio_arb_en, phy_accel_en;
    logic mpeg_stamp_fix_en, dv_stamp_fix_en;
    logic [31:0] shadow = 32'h1000, rnd = 32'h1D, q[$];
    logic [11:0] thr[4] = '{12'h800, 12'h6CC, 12'h400, 12'h200};
    int errors = 0, n_compared = 0, n_go = 0, n_ur = 0;
    async_tx_link_tuning i_async_tx_link_tuning (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ee_load_valid, .ee_load_data, .hc_ctrl,
        .async_tx_retry_limits, .fifo_level, .fifo_empty, .pkt_pending, .pkt_complete, .pkt_retry, .tx_end,
        .stream_valid, .stream_format_code, .tx_go, .tx_underrun, .tx_store_fwd, .tx_reorder_off,
        .prio_arb_en, .phy_accel_en, .mpeg_stamp_fix_en, .dv_stamp_fix_en);
    always #2.5 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    // no fixed latency assumed: wait on ack, bounded
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            errors++;
            $display("ERROR %0t: no bus acknowledge", $time);
        end
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge core_clk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        if (a == 8'hF4) begin
            if (s[0]) shadow[7:0] = d[7:0];
            if (s[1]) shadow[15:8] = d[15:8];
            shadow &= 32'h0000B582;
        end
        wb(1'h1, a, d, s);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        q.push_back(a == 8'hF4 ? shadow : 32'h0);
        wb(1'h0, a, 32'h0, 4'hF);
    endtask : rd
    task automatic pkt(input logic [11:0] lv, input logic c, input int exp);
        int g;
        g = n_go;
        fifo_level <= lv;
        pkt_complete <= c;
        pkt_pending <= 1'h1;
        repeat (6) @(posedge core_clk);
        chk(n_go - g, exp);
        pkt_pending <= 1'h0;
        tx_end <= 1'h1;
        @(posedge core_clk);
        tx_end <= 1'h0;
        @(posedge core_clk);
    endtask : pkt
    // the queue holds expected read data in request order
    always @(posedge core_clk) begin
        if (tx_go === 1'h1) n_go++;
        if (tx_underrun === 1'h1) n_ur++;
        if (wb_ack_o === 1'h1 && !wb_we_i && q.size() > 0) chk(wb_dat_o, q.pop_front());
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        int u;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'h1;
        rd(8'hF4);
        rd(8'hF0);
        $display("reset test done");
        wr(8'hF4, 32'hFFFFFFFF, 4'hF);
        rd(8'hF4);
        wr(8'hF4, 32'h0, 4'h1);
        rd(8'hF4);
        repeat (4) begin
            rnd = lfsr(rnd);
            wr(8'hF4, rnd, rnd[3:0]);
            wr(8'hF8, ~rnd, 4'hF);
            rd(8'hF4);
        end
        $display("access test done");
        ee_load_data <= 16'hFFFF;
        ee_load_valid <= 1'h1;
        @(posedge core_clk);
        ee_load_valid <= 1'h0;
        shadow = 32'h0000B582;
        rd(8'hF4);
        $display("eeprom test done");
        repeat (2) @(posedge core_clk);
        chk({tx_reorder_off, prio_arb_en, phy_accel_en}, 32'h0);
        hc_ctrl <= 32'h00400000;
        repeat (2) @(posedge core_clk);
        chk({tx_reorder_off, prio_arb_en, phy_accel_en}, 32'h7);
        stream_format_code <= 6'h20;
        stream_valid <= 1'h1;
        @(posedge core_clk);
        stream_valid <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk({mpeg_stamp_fix_en, dv_stamp_fix_en}, 32'h2);
        stream_format_code <= 6'h00;
        stream_valid <= 1'h1;
        @(posedge core_clk);
        stream_valid <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk({mpeg_stamp_fix_en, dv_stamp_fix_en}, 32'h1);
        $display("gate test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'hF4, {i[1:0], 12'h000}, 4'h2);
            pkt(thr[i] - 12'h1, 1'h0, 0);
            pkt(thr[i], 1'h0, i > 0);
            pkt(12'h10, 1'h1, 1);
        end
        async_tx_retry_limits <= 32'h0;
        pkt(12'hFFF, 1'h0, 0);
        pkt(12'h10, 1'h1, 1);
        async_tx_retry_limits <= 32'h1;
        pkt_retry <= 1'h1;
        pkt(12'hFFF, 1'h0, 0);
        pkt_retry <= 1'h0;
        $display("threshold test done");
        u = n_ur;
        fifo_level <= 12'h300;
        pkt_pending <= 1'h1;
        repeat (3) @(posedge core_clk);
        fifo_empty <= 1'h1;
        repeat (3) @(posedge core_clk);
        chk(n_ur - u, 1);
        fifo_empty <= 1'h0;
        pkt_pending <= 1'h0;
        @(posedge core_clk);
        chk(tx_store_fwd, 1'h1);
        pkt(12'h300, 1'h0, 0);
        wr(8'hF4, 32'h3000, 4'h2);
        pkt(12'h300, 1'h0, 1);
        $display("underrun test done");
        tally_and_finish();
    end
endmodule : async_tx_link_tuning_tb
bind async_tx_link_tuning atlt_sva i_atlt_sva (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .fifo_empty, .pkt_pending, .pkt_complete, .pkt_retry, .tx_go, .tx_underrun, .tx_store_fwd,
    .tx_reorder_off, .prio_arb_en, .phy_accel_en, .mpeg_stamp_fix_en, .dv_stamp_fix_en, .wb_dat_o,
    .hc_ctrl, .async_tx_retry_limits);
`default_nettype wire
